// file: rtl/iap_address_space_select.sv
// Memory space selector and program memory write control
`timescale 1ns/10ps

module iap_address_space_select #(
  parameter bit CODE_8K = 1'b1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic prog_fuse_pin,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire iap_pkg::mem_req_t cpu_req,
  output iap_pkg::mem_route_t mem_route,
  output logic nvm_write_start,
  input wire logic nvm_write_done,
  output logic cpu_idle,
  output logic cpu_resume,
  output logic program_mem_write_enable
);
  import iap_pkg::*;

  // Decide the space of one access from the current settings
  function automatic space_t map_space(input logic prog_en, input logic sign_sel,
                                       input logic dflash_en, input logic movx,
                                       input logic [15:0] addr);
    logic in_code;
    in_code = CODE_8K ? (addr <= CODE_TOP_8K) : (addr <= CODE_TOP_4K);
    map_space = SPACE_EXT_DATA;
    if (movx) begin
      if (prog_en) begin
        // Whole code window goes to the chosen array; no finer signature split
        if (in_code) begin
          map_space = sign_sel ? SPACE_SIGNATURE : SPACE_CODE;
        end
      end else if (dflash_en && addr <= FLASH_DATA_TOP) begin
        map_space = SPACE_FLASH_DATA;
      end
    end else if (sign_sel) begin
      map_space = SPACE_SIGNATURE;
    end else begin
      map_space = in_code ? SPACE_CODE : SPACE_EXT_CODE;
    end
  endfunction

  // Writes that stall the core: program code or the signature array
  function automatic logic is_prog_space(input space_t sp);
    is_prog_space = (sp == SPACE_CODE) || (sp == SPACE_SIGNATURE);
  endfunction

  // Writes that launch a page write of any kind
  function automatic logic is_page_space(input space_t sp);
    is_page_space = is_prog_space(sp) || (sp == SPACE_FLASH_DATA);
  endfunction

  // Synchroniser stages and registered state
  logic fuse_s1_r, fuse_s2_r, fuse_s3_r;
  logic fuse_ok_r, fuse_ok_nxt;
  logic [7:0] memory_control_r, memory_control_nxt;
  logic [7:0] pointer_config_r, pointer_config_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  mem_route_t route_r, route_nxt;
  wr_state_t wr_state_r, wr_state_nxt;
  logic start_r, start_nxt;
  logic idle_r, idle_nxt;
  logic resume_r, resume_nxt;
  logic iap_en_r, iap_en_nxt;
  // Settings as the decode sees them
  logic iap_eff;
  logic signature_select;
  logic data_flash_enable;
  space_t req_space;

  // Fuse is a pin; three stages, change taken when last two agree
  // A blip shorter than two cycles never reaches the enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fuse_s1_r <= 1'b0;
      fuse_s2_r <= 1'b0;
      fuse_s3_r <= 1'b0;
    end else begin
      fuse_s1_r <= prog_fuse_pin;
      fuse_s2_r <= fuse_s1_r;
      fuse_s3_r <= fuse_s2_r;
    end
  end

  // Fuse state resets to disabled, the safe side
  always_comb begin
    fuse_ok_nxt = fuse_ok_r;
    if (fuse_s2_r == fuse_s3_r) begin
      fuse_ok_nxt = fuse_s3_r;
    end
  end

  // Effective settings used by the decode
  assign iap_eff = memory_control_r[PROG_WRITE_EN_BIT] & fuse_ok_r;
  assign signature_select = pointer_config_r[SIGNATURE_SEL_BIT];
  assign data_flash_enable = memory_control_r[DATA_FLASH_EN_BIT];
  assign req_space = map_space(iap_eff, signature_select, data_flash_enable,
                               cpu_req.movx, cpu_req.addr);

  // Register writes and reads
  always_comb begin
    memory_control_nxt = memory_control_r;
    pointer_config_nxt = pointer_config_r;
    rdata_nxt = 8'h00;
    // Reserved bits are dropped on the way in, so reads need no mask
    if (sfr_wr && sfr_addr == MEMORY_CONTROL_ADDR) begin
      memory_control_nxt = sfr_wdata & ~MEMORY_CONTROL_RO0;
    end
    if (sfr_wr && sfr_addr == POINTER_CONFIG_ADDR) begin
      pointer_config_nxt = sfr_wdata & ~POINTER_CONFIG_RO0;
    end
    // Fuse off wins over any write of one
    if (!fuse_ok_r) begin
      memory_control_nxt[PROG_WRITE_EN_BIT] = 1'b0;
    end
    // Read data is registered: the address of the last cycle answers
    if (sfr_addr == MEMORY_CONTROL_ADDR) begin
      rdata_nxt = memory_control_r;
      rdata_nxt[PROG_WRITE_EN_BIT] = iap_eff;
    end else if (sfr_addr == POINTER_CONFIG_ADDR) begin
      rdata_nxt = pointer_config_r;
    end
  end

  // Route accesses and sequence nonvolatile writes
  always_comb begin
    route_nxt = '0;
    wr_state_nxt = wr_state_r;
    start_nxt = 1'b0;
    idle_nxt = idle_r;
    resume_nxt = 1'b0;
    // Same-cycle view of the enable so the output never lags the decode
    iap_en_nxt = memory_control_nxt[PROG_WRITE_EN_BIT] & fuse_ok_nxt;
    // Requests are only taken in the idle state
    case (wr_state_r)
      WR_IDLE: begin
        if (cpu_req.valid) begin
          route_nxt.valid = 1'b1;
          route_nxt.write = cpu_req.write;
          route_nxt.space = req_space;
          route_nxt.addr = cpu_req.addr;
          route_nxt.wdata = cpu_req.wdata;
          if (cpu_req.write && is_page_space(req_space)) begin
            // Same page write kick for flash data, code and signature
            start_nxt = 1'b1;
          end
          if (cpu_req.write && is_prog_space(req_space)) begin
            // Program writes also stall the core until done
            idle_nxt = 1'b1;
            wr_state_nxt = WR_WAIT;
          end
        end
      end
      WR_WAIT: begin
        // Requests are ignored; the core is stalled anyway
        // A done pulse seen in any other state is dropped
        if (nvm_write_done) begin
          idle_nxt = 1'b0;
          resume_nxt = 1'b1;
          wr_state_nxt = WR_RESUME;
        end
      end
      WR_RESUME: begin
        // One cycle gap so the next fetch follows the store
        wr_state_nxt = WR_IDLE;
      end
      default: begin
        // Stray state: go idle and release the core
        wr_state_nxt = WR_IDLE;
        idle_nxt = 1'b0;
      end
    endcase
  end

  // State registers
  // Everything clears together, so no access leaks across a reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fuse_ok_r <= 1'b0;
      memory_control_r <= MEMORY_CONTROL_RESET;
      pointer_config_r <= POINTER_CONFIG_RESET;
      rdata_r <= 8'h00;
      route_r <= '0;
      wr_state_r <= WR_IDLE;
      start_r <= 1'b0;
      idle_r <= 1'b0;
      resume_r <= 1'b0;
      iap_en_r <= 1'b0;
    end else begin
      fuse_ok_r <= fuse_ok_nxt;
      memory_control_r <= memory_control_nxt;
      pointer_config_r <= pointer_config_nxt;
      rdata_r <= rdata_nxt;
      route_r <= route_nxt;
      wr_state_r <= wr_state_nxt;
      start_r <= start_nxt;
      idle_r <= idle_nxt;
      resume_r <= resume_nxt;
      iap_en_r <= iap_en_nxt;
    end
  end

  // Outputs straight from flops
  // The enable output equals the enable the decode uses in that cycle
  assign sfr_rdata = rdata_r;
  assign mem_route = route_r;
  assign nvm_write_start = start_r;
  assign cpu_idle = idle_r;
  assign cpu_resume = resume_r;
  assign program_mem_write_enable = iap_en_r;
endmodule

// file: shared/iap_pkg.sv
// Shared constants and types for the memory space selector
package iap_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] MEMORY_CONTROL_ADDR = 8'h96;
  localparam logic [7:0] POINTER_CONFIG_ADDR = 8'hA2;
  localparam logic [7:0] MEMORY_CONTROL_RESET = 8'h00;
  localparam logic [7:0] POINTER_CONFIG_RESET = 8'h00;
  // Field positions
  localparam int PROG_WRITE_EN_BIT = 7;
  localparam int DATA_FLASH_EN_BIT = 3;
  localparam int SIGNATURE_SEL_BIT = 3;
  // Bits that always read as zero
  localparam logic [7:0] MEMORY_CONTROL_RO0 = 8'h03;
  localparam logic [7:0] POINTER_CONFIG_RO0 = 8'h06;
  // Address boundaries
  localparam logic [15:0] CODE_TOP_8K = 16'h1FFF;
  localparam logic [15:0] CODE_TOP_4K = 16'h0FFF;
  localparam logic [15:0] FLASH_DATA_TOP = 16'h00FF;
  localparam logic [15:0] SIGNATURE_TOP = 16'h01FF;

  // Destination memory space of one access
  typedef enum logic [2:0] {
    SPACE_CODE = 3'h0,
    SPACE_EXT_CODE = 3'h1,
    SPACE_FLASH_DATA = 3'h2,
    SPACE_EXT_DATA = 3'h3,
    SPACE_SIGNATURE = 3'h4
  } space_t;

  // Program write sequencer, one bit changes per step except RESUME back to IDLE
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_WAIT = 2'h1,
    WR_RESUME = 2'h3
  } wr_state_t;

  // Access issued by the CPU core
  typedef struct packed {
    logic valid;
    logic write;
    logic movx;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  // Access routed to one memory space
  typedef struct packed {
    logic valid;
    logic write;
    space_t space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_route_t;
endpackage

// file: sim/flash_model.sv
// Flash controller model answering page writes
`timescale 1ns/10ps
module flash_model #(
  parameter int DELAY = 9
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic nvm_write_start,
  output logic nvm_write_done
);
  int cnt;
  // Counts out one page write, then pulses done for one cycle
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      nvm_write_done <= 1'b0;
    end else begin
      nvm_write_done <= (cnt == 1);
      cnt <= nvm_write_start ? DELAY : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule

// file: sim/iap_address_space_select_test.sv
// Self-checking bench for the memory space selector
`timescale 1ns/10ps
module iap_address_space_select_test;
  import iap_pkg::*;
  typedef struct packed {
    logic [7:0] mc;
    logic [7:0] pc;
    logic mv;
    logic [15:0] a;
    space_t sp;
  } row_t;
  logic ref_clk = 1'b0, resetn = 1'b0, prog_fuse_pin = 1'b0, sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  mem_req_t cpu_req = '0;
  mem_route_t mem_route, route_4k;
  logic nvm_write_start, nvm_write_done, cpu_idle, cpu_resume, program_mem_write_enable;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  // Register settings, access, expected space (fuse on, 8K map)
  row_t rows [8] = '{'{8'h00, 8'h00, 1'b1, 16'h0000, SPACE_EXT_DATA},
    '{8'h08, 8'h00, 1'b1, 16'h00FF, SPACE_FLASH_DATA},
    '{8'h08, 8'h00, 1'b1, 16'h0100, SPACE_EXT_DATA},
    '{8'h00, 8'h00, 1'b0, 16'h1FFF, SPACE_CODE},
    '{8'h00, 8'h00, 1'b0, 16'h2000, SPACE_EXT_CODE},
    '{8'h00, 8'h0E, 1'b0, 16'h0100, SPACE_SIGNATURE},
    '{8'h88, 8'h00, 1'b1, 16'h1FFF, SPACE_CODE},
    '{8'h80, 8'h08, 1'b1, 16'h2000, SPACE_EXT_DATA}};
  iap_address_space_select DUT (.ref_clk, .resetn, .prog_fuse_pin, .sfr_addr, .sfr_wr,
    .sfr_wdata, .sfr_rdata, .cpu_req, .mem_route, .nvm_write_start, .nvm_write_done,
    .cpu_idle, .cpu_resume, .program_mem_write_enable);
  flash_model u_flash (.ref_clk, .resetn, .nvm_write_start, .nvm_write_done);
  // Second copy on the small map; only its route is compared
  iap_address_space_select #(.CODE_8K(1'b0)) DUT_4K (.ref_clk, .resetn, .prog_fuse_pin,
    .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata(), .cpu_req, .mem_route(route_4k),
    .nvm_write_start(), .nvm_write_done, .cpu_idle(), .cpu_resume(),
    .program_mem_write_enable());
  // 200 MHz clock
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    @(negedge ref_clk);
    chk(sfr_rdata, exp);
  endtask
  // One-cycle request; route is settled at the following falling edge
  task automatic go(input logic mv, input logic w, input logic [15:0] a);
    @(negedge ref_clk);
    cpu_req = '{1'b1, w, mv, a, 8'h5A};
    @(negedge ref_clk);
    cpu_req.valid = 1'b0;
  endtask
  // Hang guard, well above the 150 or so cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    // Six rising edges inside reset
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    rd(MEMORY_CONTROL_ADDR, MEMORY_CONTROL_RESET);
    rd(POINTER_CONFIG_ADDR, POINTER_CONFIG_RESET);
    // Fuse still off, so the enable bit is refused
    wr(MEMORY_CONTROL_ADDR, 8'h8B);
    rd(MEMORY_CONTROL_ADDR, 8'h08);
    go(1'b1, 1'b0, 16'h0000);
    chk(mem_route.space, SPACE_FLASH_DATA);
    prog_fuse_pin = 1'b1;
    repeat (8) @(negedge ref_clk);
    foreach (rows[i]) begin
      wr(MEMORY_CONTROL_ADDR, rows[i].mc);
      wr(POINTER_CONFIG_ADDR, rows[i].pc);
      go(rows[i].mv, 1'b0, rows[i].a);
      chk(mem_route.space, rows[i].sp);
    end
    // The smaller map moves the code boundary down to 1000H
    wr(POINTER_CONFIG_ADDR, 8'h00);
    go(1'b0, 1'b0, 16'h1000);
    chk({mem_route.space, route_4k.space}, {SPACE_CODE, SPACE_EXT_CODE});
    go(1'b1, 1'b0, 16'h1000);
    chk({mem_route.space, route_4k.space}, {SPACE_CODE, SPACE_EXT_DATA});
    // Flash data write kicks a page write but never stalls the core
    wr(MEMORY_CONTROL_ADDR, 8'h08);
    go(1'b1, 1'b1, 16'h0040);
    chk({mem_route.space, nvm_write_start, cpu_idle}, {SPACE_FLASH_DATA, 2'b10});
    repeat (12) @(negedge ref_clk);
    chk({cpu_idle, cpu_resume}, 2'b00);
    wr(MEMORY_CONTROL_ADDR, 8'h80);
    // Program and signature writes, with a refused request while idle
    for (int k = 0; k < 2; k++) begin
      wr(POINTER_CONFIG_ADDR, k ? 8'h08 : 8'h00);
      go(1'b1, 1'b1, 16'h0010);
      chk({mem_route.space, nvm_write_start, cpu_idle},
          {k ? SPACE_SIGNATURE : SPACE_CODE, 2'b11});
      chk({mem_route.write, mem_route.wdata}, {1'b1, 8'h5A});
      go(1'b1, 1'b0, 16'h0200);
      chk({mem_route.valid, cpu_idle}, 2'b01);
      while (cpu_resume !== 1'b1) @(negedge ref_clk);
      chk(cpu_idle, 1'b0);
      go(1'b0, 1'b0, 16'h2000);
      chk({mem_route.valid, mem_route.space},
          {1'b1, k ? SPACE_SIGNATURE : SPACE_EXT_CODE});
    end
    prog_fuse_pin = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(program_mem_write_enable, 1'b0);
    rd(MEMORY_CONTROL_ADDR, 8'h00);
    // Reset in mid-run clears the settings and every output
    rd(POINTER_CONFIG_ADDR, 8'h08);
    resetn = 1'b0;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    rd(POINTER_CONFIG_ADDR, POINTER_CONFIG_RESET);
    chk({mem_route.valid, nvm_write_start, cpu_idle, cpu_resume}, 4'h0);
    chk(program_mem_write_enable, 1'b0);
    stop_test();
  end
endmodule

// file: sim/iap_select_monitor.sv
// Port checks on the memory space selector
`timescale 1ns/10ps
module iap_select_monitor #(
  parameter bit CODE_8K = 1'b1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic prog_fuse_pin,
  input wire iap_pkg::mem_req_t cpu_req,
  input wire iap_pkg::mem_route_t mem_route,
  input wire logic nvm_write_start,
  input wire logic nvm_write_done,
  input wire logic cpu_idle,
  input wire logic cpu_resume,
  input wire logic program_mem_write_enable
);
  import iap_pkg::*;
  localparam logic [15:0] TOP = CODE_8K ? CODE_TOP_8K : CODE_TOP_4K;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Taken requests, and taken data moves with programming on
  wire tk = cpu_req.valid && !cpu_idle && !cpu_resume;
  wire en = tk && cpu_req.movx && program_mem_write_enable;
  sequence s_launch;
    nvm_write_start && mem_route.space inside {SPACE_CODE, SPACE_SIGNATURE};
  endsequence
  sequence s_back; !cpu_idle && cpu_resume ##1 !cpu_resume; endsequence
  property p_take; tk |=> mem_route.valid && mem_route.addr == $past(cpu_req.addr); endproperty
  a_take: assert property (p_take) else $error("request lost");
  property p_start; mem_route.valid && mem_route.write && mem_route.space inside
    {SPACE_CODE, SPACE_SIGNATURE, SPACE_FLASH_DATA} |-> nvm_write_start; endproperty
  a_start: assert property (p_start) else $error("no page write");
  property p_idle; s_launch |-> cpu_idle; endproperty
  a_idle: assert property (p_idle) else $error("cpu not idle");
  property p_hold; cpu_idle && !nvm_write_done |=> cpu_idle; endproperty
  a_hold: assert property (p_hold) else $error("idle dropped early");
  property p_back; cpu_idle && nvm_write_done |=> s_back; endproperty
  a_back: assert property (p_back) else $error("no resume");
  property p_lo; en && cpu_req.addr <= TOP |=>
    mem_route.space inside {SPACE_CODE, SPACE_SIGNATURE};
  endproperty
  a_lo: assert property (p_lo) else $error("move not to code");
  property p_hi; en && cpu_req.addr > TOP |=> mem_route.space == SPACE_EXT_DATA; endproperty
  a_hi: assert property (p_hi) else $error("high move misrouted");
  property p_fuse; !prog_fuse_pin [*8] |-> !program_mem_write_enable; endproperty
  a_fuse: assert property (p_fuse) else $error("enable without fuse");
endmodule
bind iap_address_space_select iap_select_monitor #(.CODE_8K(CODE_8K)) u_mon (.ref_clk,
  .resetn, .prog_fuse_pin, .cpu_req, .mem_route, .nvm_write_start, .nvm_write_done,
  .cpu_idle, .cpu_resume, .program_mem_write_enable);
